// >>> pdh_pin_power_down_hold.sv
/*
  pdh_pin_power_down_hold: power-down hold logic between the pins and the
  logic array. While the control pin is high and the option is built in,
  pin levels seen by the array, output data and output enables are frozen
  and the array is told to hold its state.
  Assumes all pins are synchronous to core_clk and that the enable input
  is a static build-time strap.
*/
`timescale 1ns/1ps
module pdh_pin_power_down_hold
  import pdh_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // configuration strap and control pin
  input wire logic power_down_enable,
  input wire logic power_down_pin,
  // device pins
  input wire logic [PDH_IN_W-1:0] in_pin,
  input wire logic [PDH_IO_W-1:0] io_in,
  output logic [PDH_IO_W-1:0] io_out,
  output logic [PDH_IO_W-1:0] io_oe_n,
  // logic array side
  output logic [PDH_IN_W-1:0] array_in,
  output logic [PDH_IO_W-1:0] array_io_in,
  input wire logic [PDH_IO_W-1:0] array_out,
  input wire logic [PDH_IO_W-1:0] array_oe_n,
  output logic array_freeze,
  output logic pd_pin_to_array,
  // macrocell of the control pin
  input wire logic pd_mc_fb_in,
  output logic pd_mc_fb_out,
  // status
  output logic power_down_active
);

  // ==========================================================
  // control
  pdh_state_type state;
  pdh_state_type next_state;
  logic [PDH_CNT_W-1:0] wake_cnt;
  logic pd_req;
  logic capture;

  // without the option the pin never requests power-down
  assign pd_req = power_down_enable & power_down_pin;
  // blocking starts at the very edge the pin is seen high
  assign capture = (state == PDH_RUN) && !pd_req;

  always_comb
  begin
    next_state = state;
    case (state)
      PDH_RUN:
      begin
        if (pd_req)
        begin
          next_state = PDH_DOWN;
        end
      end
      PDH_DOWN:
      begin
        if (!pd_req)
        begin
          next_state = PDH_WAKE;
        end
      end
      PDH_WAKE:
      begin
        if (pd_req)
        begin
          next_state = PDH_DOWN;
        end
        else if (wake_cnt == PDH_WAKE_LAST)
        begin
          next_state = PDH_RUN;
        end
      end
      default:
      begin
        next_state = PDH_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= PDH_RUN;
    end
    else
    begin
      state <= next_state;
    end
  end

  // wake counter: outputs stay frozen until the wake time has passed
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wake_cnt <= PDH_CNT_RST;
    end
    else if (state == PDH_WAKE && !pd_req)
    begin
      wake_cnt <= wake_cnt + 7'h01;
    end
    else
    begin
      wake_cnt <= PDH_CNT_RST;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      array_freeze <= 1'h0;
      power_down_active <= 1'h0;
    end
    else
    begin
      // array registers hold while frozen; released with the outputs
      array_freeze <= (next_state != PDH_RUN);
      power_down_active <= (next_state == PDH_DOWN);
    end
  end

  // ==========================================================
  // pin side hold latches
  // these keep the last valid pin level, so a floating or changing pin
  // cannot reach the array while powered down
  pdh_hold_reg #(.WIDTH(PDH_IN_W), .RST_VAL('0)) u_in_hold
  (
    .core_clk(core_clk),
    .reset(reset),
    .capture(capture),
    .d(in_pin),
    .q(array_in)
  );

  pdh_hold_reg #(.WIDTH(PDH_IO_W), .RST_VAL('0)) u_io_hold
  (
    .core_clk(core_clk),
    .reset(reset),
    .capture(capture),
    .d(io_in),
    .q(array_io_in)
  );

  // ==========================================================
  // output hold: data and enables frozen together so a pin that was
  // released at entry cannot start driving
  pdh_hold_reg #(.WIDTH(PDH_IO_W), .RST_VAL('0)) u_out_hold
  (
    .core_clk(core_clk),
    .reset(reset),
    .capture(capture),
    .d(array_out),
    .q(io_out)
  );

  pdh_hold_reg #(.WIDTH(PDH_IO_W), .RST_VAL({PDH_IO_W{PDH_OE_N_RST}}))
    u_oe_hold
  (
    .core_clk(core_clk),
    .reset(reset),
    .capture(capture),
    .d(array_oe_n),
    .q(io_oe_n)
  );

  // ==========================================================
  // control pin macrocell
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pd_pin_to_array <= 1'h0;
      pd_mc_fb_out <= 1'h0;
    end
    else
    begin
      // reserved pin reads as zero in the array when the option is on
      pd_pin_to_array <= power_down_enable ? 1'h0 : power_down_pin;
      // buried feedback keeps running, it is internal to the array
      pd_mc_fb_out <= pd_mc_fb_in;
    end
  end

  // ==========================================================
  // checks
  AST_ENTER: assert property (@(posedge core_clk) disable iff (reset)
    (state == PDH_RUN && power_down_enable && power_down_pin)
      |=> (state == PDH_DOWN && array_freeze && power_down_active))
    else $error("power-down not entered on pin high");

  AST_HOLD_OUT: assert property (@(posedge core_clk) disable iff (reset)
    (state == PDH_DOWN) [*2] |-> $stable(io_out))
    else $error("output data changed during power-down");

  AST_HOLD_OE: assert property (@(posedge core_clk) disable iff (reset)
    !capture |=> (io_oe_n == $past(io_oe_n)))
    else $error("output enable changed during power-down");

  AST_BLOCK_IN: assert property (@(posedge core_clk) disable iff (reset)
    !capture |=> ($stable(array_in) && $stable(array_io_in)))
    else $error("input reached the array during power-down");

  AST_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    (capture ##1 !capture) |-> (array_io_in == $past(io_in)))
    else $error("hold latch lost the last pin level");

  AST_STATIC: assert property (@(posedge core_clk) disable iff (reset)
    (!power_down_enable && state == PDH_RUN)
      |=> (state == PDH_RUN && !array_freeze))
    else $error("pin acted without the option");

  AST_NO_ARRAY: assert property (@(posedge core_clk) disable iff (reset)
    power_down_enable |=> !pd_pin_to_array)
    else $error("reserved pin fed the array");

  AST_MC_FB: assert property (@(posedge core_clk) disable iff (reset)
    (state == PDH_DOWN) |=> (pd_mc_fb_out == $past(pd_mc_fb_in)))
    else $error("control pin macrocell feedback stalled");

  // cycles spent waking, counted apart from the wake counter above;
  // a pin that rises again mid-wake sends the state back to DOWN,
  // which restarts this count
  logic [PDH_CNT_W-1:0] wake_len;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wake_len <= PDH_CNT_RST;
    end
    else if (state == PDH_WAKE)
    begin
      wake_len <= wake_len + 7'h01;
    end
    else
    begin
      wake_len <= PDH_CNT_RST;
    end
  end

  AST_WAKE: assert property (@(posedge core_clk) disable iff (reset)
    (state == PDH_WAKE && wake_len == PDH_WAKE_LAST && !pd_req)
      |=> (state == PDH_RUN && !array_freeze))
    else $error("sampling did not resume after the wake time");

  AST_WAKE_EARLY: assert property (@(posedge core_clk) disable iff (reset)
    (state == PDH_WAKE && wake_len != PDH_WAKE_LAST)
      |=> (state != PDH_RUN && array_freeze))
    else $error("sampling resumed before the wake time");

endmodule : pdh_pin_power_down_hold

// >>> pdh_pkg.sv
/*
  pdh_pkg: constants for the pin controlled power-down hold block.
  Assumes a single 100 MHz core clock; all times converted to cycles here.
*/
package pdh_pkg;

  // ==========================================================
  // widths
  localparam int PDH_IO_W = 64;
  localparam int PDH_IN_W = 4;
  localparam int PDH_CNT_W = 7;

  // ==========================================================
  // timing
  localparam int PDH_CLK_PERIOD_PS = 10000;
  // pin low to valid inputs, clocks, enables and outputs, longest time
  localparam int PDH_WAKE_TIME_NS = 1000;
  localparam int PDH_WAKE_RAW = (PDH_WAKE_TIME_NS * 1000) / PDH_CLK_PERIOD_PS;
  localparam int PDH_WAKE_CYC = (PDH_WAKE_RAW < 1) ? 1 : PDH_WAKE_RAW;
  localparam logic [PDH_CNT_W-1:0] PDH_WAKE_LAST =
    PDH_CNT_W'(PDH_WAKE_CYC - 1);

  // ==========================================================
  // reset values
  localparam logic [PDH_CNT_W-1:0] PDH_CNT_RST = 7'h00;
  localparam logic PDH_OE_N_RST = 1'h1;

  // ==========================================================
  // states, gray along run -> down -> wake
  typedef enum logic [1:0] {
    PDH_RUN = 2'h0,
    PDH_DOWN = 2'h1,
    PDH_WAKE = 2'h3
  } pdh_state_type;

endpackage : pdh_pkg

// >>> pdh_hold_reg.sv
/*
  pdh_hold_reg: a word that follows its input while capture is high
  and holds its last value otherwise.
  Assumes synchronous inputs and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module pdh_hold_reg #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // data
  input wire logic capture,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      q <= RST_VAL;
    end
    else if (capture)
    begin
      q <= d;
    end
  end

endmodule : pdh_hold_reg

// >>> pdh_board_model.sv
/*
  pdh_board_model: board logic that drives the power-down control pin.
  Assumes the bench asks for power-down on want_down; the pin is always
  driven, so it never floats.
*/
`timescale 1ns/1ps
module pdh_board_model (
  // clock
  input wire logic core_clk,
  // request from the bench
  input wire logic want_down,
  // control pin
  output logic power_down_pin
);
  // ==========================================================
  // pin path
  // a plain buffer: the pin moves when the bench moves the request on
  // the falling edge, with no race against a second falling-edge process
  assign power_down_pin = want_down;
endmodule : pdh_board_model

// >>> pdh_pin_power_down_hold_tb.sv
/*
  pdh_pin_power_down_hold_tb: self-checking bench for the power-down hold.
  Assumes the board model drives the control pin; inputs change on the
  falling edge of core_clk.
*/
`timescale 1ns/1ps
module pdh_pin_power_down_hold_tb
  import pdh_pkg::*;
;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic power_down_enable = 1'h1;
  logic want_down = 1'h0;
  logic power_down_pin, pd_mc_fb_in, pd_mc_fb_out;
  logic [PDH_IN_W-1:0] in_pin, array_in;
  logic [PDH_IO_W-1:0] io_in, io_out, io_oe_n, array_io_in;
  logic [PDH_IO_W-1:0] array_out, array_oe_n;
  logic array_freeze, pd_pin_to_array, power_down_active;
  int fail_count = 0;
  int checks_done = 0;
  int i;

  always #5 core_clk = ~core_clk;

  pdh_board_model pdh_board_model_inst (.core_clk(core_clk),
    .want_down(want_down), .power_down_pin(power_down_pin));

  pdh_pin_power_down_hold pdh_pin_power_down_hold_inst (
    .core_clk(core_clk), .reset(reset),
    .power_down_enable(power_down_enable),
    .power_down_pin(power_down_pin), .in_pin(in_pin), .io_in(io_in),
    .io_out(io_out), .io_oe_n(io_oe_n), .array_in(array_in),
    .array_io_in(array_io_in), .array_out(array_out),
    .array_oe_n(array_oe_n), .array_freeze(array_freeze),
    .pd_pin_to_array(pd_pin_to_array), .pd_mc_fb_in(pd_mc_fb_in),
    .pd_mc_fb_out(pd_mc_fb_out), .power_down_active(power_down_active));

  // ==========================================================
  // helpers
  task chk(input bit ok, input string msg);
    checks_done++;
    if (!ok)
    begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // leaves in i the falling edges waited until the freeze drops
  task wait_thaw;
    for (i = 0; i < 150 && array_freeze !== 1'h0; i++)
      cyc(1);
    if (i == 150)
    begin
      chk(1'b0, "wake timeout");
      test_done();
    end
  endtask : wait_thaw

  // upper half of the enables takes the low word of v, the lower half its inverse
  task drive(input logic [63:0] v);
    in_pin = v[3:0];
    io_in = v;
    array_out = ~v;
    array_oe_n = {v[31:0], ~v[31:0]};
    pd_mc_fb_in = v[0];
  endtask : drive

  task held(input logic [63:0] v, input string m);
    chk(array_in === v[3:0] && array_io_in === v && io_out === ~v &&
      io_oe_n === {v[31:0], ~v[31:0]}, m);
  endtask : held

  // ==========================================================
  // scenarios
  task t_run;
    drive(64'h0123_4567_89ab_cdef);
    cyc(2);
    held(64'h0123_4567_89ab_cdef, "run capture");
    chk(pd_pin_to_array === 1'h0, "pin reached array");
    chk(pd_mc_fb_out === 1'h1, "feedback lost");
  endtask : t_run

  task t_down;
    want_down = 1'h1;
    cyc(1);
    drive(64'hfedc_ba98_7654_3210);
    cyc(3);
    chk(power_down_active === 1'h1 && array_freeze === 1'h1, "no entry");
    held(64'h0123_4567_89ab_cdef, "not held");
    chk(pd_pin_to_array === 1'h0, "pin reached array");
    chk(pd_mc_fb_out === 1'h0, "feedback frozen");
    want_down = 1'h0;
    cyc(3);
    chk(power_down_active === 1'h0, "still down");
    held(64'h0123_4567_89ab_cdef, "early wake");
    wait_thaw();
    // freeze drops one cycle past the wake time counted from the pin edge
    chk(i + 3 == PDH_WAKE_CYC + 1, "wake time wrong");
    cyc(2);
    held(64'hfedc_ba98_7654_3210, "no resume");
  endtask : t_down

  task t_off;
    power_down_enable = 1'h0;
    want_down = 1'h1;
    cyc(1);
    drive(64'h5a5a_0f0f_a5a5_f0f0);
    cyc(3);
    chk(power_down_active === 1'h0 && array_freeze === 1'h0, "entered");
    held(64'h5a5a_0f0f_a5a5_f0f0, "blocked");
    chk(pd_pin_to_array === 1'h1, "pin not passed");
    want_down = 1'h0;
    cyc(2);
    power_down_enable = 1'h1;
    cyc(2);
  endtask : t_off

  // pin rising again mid-wake must go back down and restart the wake
  task t_rewake;
    want_down = 1'h1;
    cyc(2);
    want_down = 1'h0;
    cyc(10);
    chk(power_down_active === 1'h0 && array_freeze === 1'h1, "no wake");
    want_down = 1'h1;
    cyc(2);
    chk(power_down_active === 1'h1, "wake not cut");
    want_down = 1'h0;
    cyc(1);
    wait_thaw();
    chk(i + 1 == PDH_WAKE_CYC + 1, "wake not restarted");
  endtask : t_rewake

  task t_reset;
    chk(io_out === '0 && io_oe_n === '1, "reset outputs");
    chk(array_in === '0 && array_io_in === '0, "reset inputs");
    chk(array_freeze === 1'h0, "reset freeze");
    chk(power_down_active === 1'h0, "reset active");
    chk(pd_pin_to_array === 1'h0 && pd_mc_fb_out === 1'h0, "reset pin");
  endtask : t_reset

  // reset in the middle of power-down, then capture must resume
  task t_reset_mid;
    want_down = 1'h1;
    cyc(2);
    chk(power_down_active === 1'h1, "no entry before reset");
    reset = 1'h1;
    want_down = 1'h0;
    cyc(2);
    t_reset();
    reset = 1'h0;
    cyc(2);
    held(64'h5a5a_0f0f_a5a5_f0f0, "no capture after reset");
  endtask : t_reset_mid

  // ==========================================================
  // main sequence
  initial
  begin
    drive(64'h0);
    cyc(20);
    t_reset();
    reset = 1'h0;
    t_run();
    t_down();
    t_rewake();
    t_off();
    t_reset_mid();
    test_done();
  end
endmodule : pdh_pin_power_down_hold_tb
